// >>> logic/clock_pll_regs.vh
// Register offsets, field positions, reset values and serial frame layout for the clock synthesizer group
`ifndef CLOCK_PLL_REGS_VH
`define CLOCK_PLL_REGS_VH

// Register offsets on the serial control port
`define OFS_REF_OUTPUT_CONTROL 15'h003C
`define OFS_FEEDBACK_DIVIDER_FIRST_SECOND 15'h003D
`define OFS_FEEDBACK_DIVIDER_THIRD 15'h003E
`define OFS_OSCILLATOR_BIAS_CONTROL 15'h003F
`define OFS_LANE_EMPHASIS_SETTING 15'h0048

// Reset values
`define RST_REF_OUTPUT_CONTROL 8'h01
`define RST_FEEDBACK_DIVIDER_FIRST_SECOND 8'h00
`define RST_FEEDBACK_DIVIDER_THIRD 8'h20
`define RST_OSCILLATOR_BIAS_CONTROL 8'h4F
`define RST_LANE_EMPHASIS_SETTING 8'h00

// Field positions
`define BIT_REF_CLOCK_OUT_ENABLE 0
`define FLD_FIRST_DIV_HI 1
`define FLD_FIRST_DIV_LO 0
`define FLD_SECOND_DIV_HI 3
`define FLD_SECOND_DIV_LO 2
`define FLD_THIRD_DIV_HI 5
`define FLD_THIRD_DIV_LO 0
`define FLD_BIAS_HI 6
`define FLD_BIAS_LO 0
`define FLD_PREEMPH_HI 3
`define FLD_PREEMPH_LO 0

// Divider ratios for each code
`define FIRST_RATIO_CODE0 6'h05
`define FIRST_RATIO_CODE1 6'h04
`define FIRST_RATIO_CODE2 6'h03
`define SECOND_RATIO_CODE0 6'h01
`define SECOND_RATIO_CODE1 6'h02
`define SECOND_RATIO_CODE2 6'h04

// Serial frame: one read flag, 15 address bits, 8 data bits
`define FRAME_ADDR_BITS 15
`define FRAME_DATA_BITS 8
`define FRAME_HEAD_COUNT 5'h10
`define FRAME_TOTAL_COUNT 5'h18

`endif

// >>> logic/serial_control_port.v
// Serial control port slave: synchronises the host pins and turns frames into register accesses
`timescale 1ns/1ns
module serial_control_port (
  input wire clock,
  input wire nrst,
  input wire port_sclk,
  input wire port_cs_n,
  input wire port_sdi,
  input wire [7:0] rd_data,
  output reg [14:0] acc_addr_reg,
  output reg [7:0] wr_data_reg,
  output reg wr_strobe_reg,
  output reg port_sdo_reg,
  output reg port_sdo_oe_reg
);
  `include "clock_pll_regs.vh"

  reg [2:0] sclk_sync_reg;
  reg [1:0] cs_sync_reg;
  reg [1:0] sdi_sync_reg;
  reg [4:0] bit_count_reg;
  reg [22:0] shift_in_reg;
  reg read_flag_reg;
  reg load_pending_reg;
  reg [7:0] shift_out_reg;
  wire sclk_rise;
  wire sclk_fall;
  wire cs_active;

  // Two-flop synchronisers; third sclk stage exists only for edge detection
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sclk_sync_reg <= 3'h0;
      cs_sync_reg <= 2'h3;
      sdi_sync_reg <= 2'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], port_sclk};
      cs_sync_reg <= {cs_sync_reg[0], port_cs_n};
      sdi_sync_reg <= {sdi_sync_reg[0], port_sdi};
    end
  end

  assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
  assign cs_active = ~cs_sync_reg[1];

  // Frame shifter: sample on rising sclk, drive read data on falling sclk
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bit_count_reg <= 5'h00;
      shift_in_reg <= 23'h000000;
      read_flag_reg <= 1'b0;
      load_pending_reg <= 1'b0;
      shift_out_reg <= 8'h00;
      acc_addr_reg <= 15'h0000;
      wr_data_reg <= 8'h00;
      wr_strobe_reg <= 1'b0;
      port_sdo_reg <= 1'b0;
      port_sdo_oe_reg <= 1'b0;
    end else begin
      wr_strobe_reg <= 1'b0;
      if (!cs_active) begin
        // Deselect aborts any partial frame, so a short frame never writes
        bit_count_reg <= 5'h00;
        load_pending_reg <= 1'b0;
        port_sdo_oe_reg <= 1'b0;
      end else begin
        if (load_pending_reg) begin
          shift_out_reg <= rd_data;
          load_pending_reg <= 1'b0;
        end
        if (sclk_rise && bit_count_reg != `FRAME_TOTAL_COUNT) begin
          shift_in_reg <= {shift_in_reg[21:0], sdi_sync_reg[1]};
          bit_count_reg <= bit_count_reg + 5'h01;
          if (bit_count_reg == 5'h00) begin
            read_flag_reg <= sdi_sync_reg[1];
          end
          if (bit_count_reg == `FRAME_HEAD_COUNT - 5'h01) begin
            acc_addr_reg <= {shift_in_reg[13:0], sdi_sync_reg[1]};
            load_pending_reg <= read_flag_reg;
          end
          if (bit_count_reg == `FRAME_TOTAL_COUNT - 5'h01 && !read_flag_reg) begin
            wr_data_reg <= {shift_in_reg[6:0], sdi_sync_reg[1]};
            wr_strobe_reg <= 1'b1;
          end
        end
        if (sclk_fall && read_flag_reg && bit_count_reg >= `FRAME_HEAD_COUNT &&
            bit_count_reg != `FRAME_TOTAL_COUNT) begin
          port_sdo_reg <= shift_out_reg[7];
          port_sdo_oe_reg <= 1'b1;
          shift_out_reg <= {shift_out_reg[6:0], 1'b0};
        end
      end
    end
  end
endmodule // serial_control_port

// >>> logic/tick_divider.v
// Programmable divider of a one-cycle tick stream
`timescale 1ns/1ns
module tick_divider #(
  parameter WIDTH = 6
) (
  input wire clock,
  input wire nrst,
  input wire hold,
  input wire tick_in,
  input wire [WIDTH-1:0] ratio,
  output reg tick_out
);
  reg [WIDTH-1:0] count_reg;
  wire [WIDTH-1:0] last_count;

  // A ratio of zero behaves as divide-by-1 so the chain never stalls
  assign last_count = (ratio == {WIDTH{1'b0}}) ? {WIDTH{1'b0}} : ratio - {{(WIDTH-1){1'b0}}, 1'b1};

  // Count input ticks and emit one tick every ratio inputs
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count_reg <= {WIDTH{1'b0}};
      tick_out <= 1'b0;
    end else if (hold) begin
      count_reg <= {WIDTH{1'b0}};
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (count_reg >= last_count) begin
          count_reg <= {WIDTH{1'b0}};
          tick_out <= 1'b1;
        end else begin
          count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // tick_divider

// >>> logic/clock_pll_config_regs.v
// Clock synthesizer configuration registers, feedback divider chain model and lane pre-emphasis fan-out
//
// Contract
// - Reference clock output driven only while its enable bit and the PLL enable pin are high.
// - Reference output enable bit resets to 1, so output runs without any write.
// - Second divider code at bits 3:2: 0 divides by 1, 1 by 2, 2 by 4.
// - Second divider output is the converter sampling clock.
// - First divider code at bits 1:0: 0 divides by 5, 1 by 4, 2 by 3.
// - First divider output feeds the second divider, forming a cascade.
// - Third divider field at bits 5:0 is a direct ratio 1 to 63, reset 0x20.
// - Feedback clock is the sampling clock divided by the third ratio.
// - Pre-emphasis code at bits 3:0 applies globally to every serial lane.
`timescale 1ns/1ns
module clock_pll_config_regs #(
  parameter LANES = 8
) (
  input wire clock,
  input wire nrst,
  input wire port_sclk,
  input wire port_cs_n,
  input wire port_sdi,
  input wire pll_enable_pin,
  input wire clock_pll_reset,
  input wire oscillator_tick,
  output reg port_sdo,
  output reg port_sdo_oe,
  output reg ref_clock_output_pins,
  output reg ref_clock_output_oe,
  output reg sampling_clock_tick,
  output reg feedback_clock_tick,
  output reg [6:0] oscillator_bias_level,
  output reg [4*LANES-1:0] lane_preemphasis
);
  `include "clock_pll_regs.vh"

  reg [7:0] ref_output_control_reg;
  reg [7:0] feedback_divider_first_second_reg;
  reg [7:0] feedback_divider_third_reg;
  reg [7:0] oscillator_bias_control_reg;
  reg [7:0] lane_emphasis_setting_reg;
  reg [1:0] pll_en_sync_reg;
  reg [7:0] rd_data_next;
  wire [4*LANES-1:0] lane_preemphasis_next;
  wire [4:0] reg_sel;
  wire [4:0] wr_sel;
  wire ref_gate;
  wire [14:0] acc_addr;
  wire [7:0] wr_data;
  wire wr_strobe;
  wire spi_sdo;
  wire spi_sdo_oe;
  wire first_tick;
  wire second_tick;
  wire third_tick;
  wire [5:0] first_ratio;
  wire [5:0] second_ratio;
  wire [5:0] third_ratio;
  wire ref_out_enable;
  genvar lane;

  // Bit positions in the one-hot register select
  localparam SEL_REF = 0;
  localparam SEL_FIRST_SECOND = 1;
  localparam SEL_THIRD = 2;
  localparam SEL_BIAS = 3;
  localparam SEL_EMPHASIS = 4;

  // Address compare shared by the write and read paths
  function addr_hit;
    input [14:0] addr;
    input [14:0] offset;
    begin
      addr_hit = (addr == offset);
    end
  endfunction

  // One-hot register select for the write enables
  function [4:0] reg_select;
    input [14:0] addr;
    begin
      reg_select = 5'h00;
      reg_select[SEL_REF] = addr_hit(addr, `OFS_REF_OUTPUT_CONTROL);
      reg_select[SEL_FIRST_SECOND] = addr_hit(addr, `OFS_FEEDBACK_DIVIDER_FIRST_SECOND);
      reg_select[SEL_THIRD] = addr_hit(addr, `OFS_FEEDBACK_DIVIDER_THIRD);
      reg_select[SEL_BIAS] = addr_hit(addr, `OFS_OSCILLATOR_BIAS_CONTROL);
      reg_select[SEL_EMPHASIS] = addr_hit(addr, `OFS_LANE_EMPHASIS_SETTING);
    end
  endfunction

  // First divider code to ratio; reserved code keeps the default ratio
  function [5:0] first_decode;
    input [1:0] code;
    begin
      case (code)
        2'h0: first_decode = `FIRST_RATIO_CODE0;
        2'h1: first_decode = `FIRST_RATIO_CODE1;
        2'h2: first_decode = `FIRST_RATIO_CODE2;
        default: first_decode = `FIRST_RATIO_CODE0;
      endcase
    end
  endfunction

  // Second divider code to ratio; reserved code keeps the default ratio
  function [5:0] second_decode;
    input [1:0] code;
    begin
      case (code)
        2'h0: second_decode = `SECOND_RATIO_CODE0;
        2'h1: second_decode = `SECOND_RATIO_CODE1;
        2'h2: second_decode = `SECOND_RATIO_CODE2;
        default: second_decode = `SECOND_RATIO_CODE0;
      endcase
    end
  endfunction

  serial_control_port u_port (
    .clock(clock),
    .nrst(nrst),
    .port_sclk(port_sclk),
    .port_cs_n(port_cs_n),
    .port_sdi(port_sdi),
    .rd_data(rd_data_next),
    .acc_addr_reg(acc_addr),
    .wr_data_reg(wr_data),
    .wr_strobe_reg(wr_strobe),
    .port_sdo_reg(spi_sdo),
    .port_sdo_oe_reg(spi_sdo_oe)
  );

  // Write enables; whole bytes are stored, reserved bits included, and held until the next write or reset
  assign reg_sel = reg_select(acc_addr);
  assign wr_sel = reg_sel & {5{wr_strobe}};

  // Reference output control; the enable bit comes up set so the output runs before any write
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ref_output_control_reg <= `RST_REF_OUTPUT_CONTROL;
    end else if (wr_sel[SEL_REF]) begin
      ref_output_control_reg <= wr_data;
    end
  end

  // First and second divider codes; the host holds the dividers in reset while changing them
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      feedback_divider_first_second_reg <= `RST_FEEDBACK_DIVIDER_FIRST_SECOND;
    end else if (wr_sel[SEL_FIRST_SECOND]) begin
      feedback_divider_first_second_reg <= wr_data;
    end
  end

  // Third divider ratio
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      feedback_divider_third_reg <= `RST_FEEDBACK_DIVIDER_THIRD;
    end else if (wr_sel[SEL_THIRD]) begin
      feedback_divider_third_reg <= wr_data;
    end
  end

  // Oscillator bias; its reset value is not the one to run the synthesizer with
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      oscillator_bias_control_reg <= `RST_OSCILLATOR_BIAS_CONTROL;
    end else if (wr_sel[SEL_BIAS]) begin
      oscillator_bias_control_reg <= wr_data;
    end
  end

  // Lane pre-emphasis code
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lane_emphasis_setting_reg <= `RST_LANE_EMPHASIS_SETTING;
    end else if (wr_sel[SEL_EMPHASIS]) begin
      lane_emphasis_setting_reg <= wr_data;
    end
  end

  // Read-back mux; addresses outside the group read as zero
  always @* begin
    rd_data_next = 8'h00;
    if (addr_hit(acc_addr, `OFS_REF_OUTPUT_CONTROL)) begin
      rd_data_next = ref_output_control_reg;
    end
    if (addr_hit(acc_addr, `OFS_FEEDBACK_DIVIDER_FIRST_SECOND)) begin
      rd_data_next = feedback_divider_first_second_reg;
    end
    if (addr_hit(acc_addr, `OFS_FEEDBACK_DIVIDER_THIRD)) begin
      rd_data_next = feedback_divider_third_reg;
    end
    if (addr_hit(acc_addr, `OFS_OSCILLATOR_BIAS_CONTROL)) begin
      rd_data_next = oscillator_bias_control_reg;
    end
    if (addr_hit(acc_addr, `OFS_LANE_EMPHASIS_SETTING)) begin
      rd_data_next = lane_emphasis_setting_reg;
    end
  end

  // The enable pin is asynchronous to our clock
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pll_en_sync_reg <= 2'h0;
    end else begin
      pll_en_sync_reg <= {pll_en_sync_reg[0], pll_enable_pin};
    end
  end

  assign ref_out_enable = ref_output_control_reg[`BIT_REF_CLOCK_OUT_ENABLE];
  // The enable bit only counts while the PLL enable pin is high
  assign ref_gate = ref_out_enable & pll_en_sync_reg[1];

  // Field decode; the divider chain is only a tick model of the analog loop
  assign first_ratio = first_decode(
    feedback_divider_first_second_reg[`FLD_FIRST_DIV_HI:`FLD_FIRST_DIV_LO]);
  assign second_ratio = second_decode(
    feedback_divider_first_second_reg[`FLD_SECOND_DIV_HI:`FLD_SECOND_DIV_LO]);
  assign third_ratio = feedback_divider_third_reg[`FLD_THIRD_DIV_HI:`FLD_THIRD_DIV_LO];

  // Divider state is cleared while the host holds the PLL in reset, so ratio changes start clean
  tick_divider #(.WIDTH(6)) u_first_div (
    .clock(clock),
    .nrst(nrst),
    .hold(clock_pll_reset),
    .tick_in(oscillator_tick),
    .ratio(first_ratio),
    .tick_out(first_tick)
  );

  // First stage output drives the second stage
  tick_divider #(.WIDTH(6)) u_second_div (
    .clock(clock),
    .nrst(nrst),
    .hold(clock_pll_reset),
    .tick_in(first_tick),
    .ratio(second_ratio),
    .tick_out(second_tick)
  );

  // Sampling clock divided by the direct ratio yields the detector feedback
  tick_divider #(.WIDTH(6)) u_third_div (
    .clock(clock),
    .nrst(nrst),
    .hold(clock_pll_reset),
    .tick_in(second_tick),
    .ratio(third_ratio),
    .tick_out(third_tick)
  );

  // Global pre-emphasis fanned out to every lane
  generate
    for (lane = 0; lane < LANES; lane = lane + 1) begin : g_lane
      assign lane_preemphasis_next[4*lane +: 4] =
        lane_emphasis_setting_reg[`FLD_PREEMPH_HI:`FLD_PREEMPH_LO];
    end
  endgenerate

  // Serial read data re-registered so the pins come straight from flip-flops
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      port_sdo <= 1'b0;
      port_sdo_oe <= 1'b0;
    end else begin
      port_sdo <= spi_sdo;
      port_sdo_oe <= spi_sdo_oe;
    end
  end

  // Reference output carries the oscillator ticks only while gated on; one gate keeps both in step
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ref_clock_output_pins <= 1'b0;
      ref_clock_output_oe <= 1'b0;
    end else begin
      ref_clock_output_oe <= ref_gate;
      ref_clock_output_pins <= ref_gate & oscillator_tick;
    end
  end

  // Divider ticks, one flop after the chain
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sampling_clock_tick <= 1'b0;
      feedback_clock_tick <= 1'b0;
    end else begin
      sampling_clock_tick <= second_tick;
      feedback_clock_tick <= third_tick;
    end
  end

  // Field outputs; they read zero during reset and take the defaults one edge after release
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      oscillator_bias_level <= 7'h00;
      lane_preemphasis <= {4*LANES{1'b0}};
    end else begin
      oscillator_bias_level <= oscillator_bias_control_reg[`FLD_BIAS_HI:`FLD_BIAS_LO];
      lane_preemphasis <= lane_preemphasis_next;
    end
  end
endmodule // clock_pll_config_regs

// >>> tb/clock_pll_config_regs_sva.sv
// Port assertions for the clock synthesizer register group
`timescale 1ns/1ns
module clock_pll_config_regs_sva #(
  parameter LANES = 8
) (
  input wire clock,
  input wire nrst,
  input wire port_cs_n,
  input wire pll_enable_pin,
  input wire clock_pll_reset,
  input wire oscillator_tick,
  input wire port_sdo_oe,
  input wire ref_clock_output_pins,
  input wire ref_clock_output_oe,
  input wire sampling_clock_tick,
  input wire feedback_clock_tick,
  input wire [6:0] oscillator_bias_level,
  input wire [4*LANES-1:0] lane_preemphasis
);
  reg [3:0] age_reg;
  // Edges since reset release; the first edges still load reset values
  always @(posedge clock or negedge nrst) begin
    if (!nrst)
      age_reg <= 4'h0;
    else if (age_reg != 4'hF)
      age_reg <= age_reg + 4'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence pll_low4; !pll_enable_pin [*4]; endsequence
  sequence pll_high4; pll_enable_pin [*4]; endsequence
  // Long enough for a write that ends the frame to have landed
  sequence idle8; port_cs_n [*8] ##0 (age_reg == 4'hF); endsequence
  a_pins_gated_tick: assert property (ref_clock_output_pins == (ref_clock_output_oe && $past(oscillator_tick)))
    else $error("reference pins not the gated tick");
  a_oe_pll_low: assert property (pll_low4 |-> !ref_clock_output_oe)
    else $error("reference output enabled while pll pin low");
  a_oe_boot_on: assert property (pll_high4 ##0 (age_reg == 4'h6) |-> ref_clock_output_oe)
    else $error("reference output not enabled after reset");
  a_reset_defaults: assert property (age_reg == 4'h4 |-> oscillator_bias_level == 7'h4F && lane_preemphasis == 0)
    else $error("field outputs not at reset defaults");
  a_lanes_global: assert property (lane_preemphasis == {LANES{lane_preemphasis[3:0]}})
    else $error("lanes differ in pre-emphasis");
  a_idle_fields_hold: assert property (idle8 |-> $stable(oscillator_bias_level) && $stable(lane_preemphasis))
    else $error("field output changed without a frame");
  a_divider_held: assert property (clock_pll_reset [*4] |-> !sampling_clock_tick && !feedback_clock_tick)
    else $error("divider tick while held in reset");
  a_sample_pulse: assert property (sampling_clock_tick |=> !sampling_clock_tick)
    else $error("sampling tick longer than one cycle");
  a_feedback_pulse: assert property (feedback_clock_tick |=> !feedback_clock_tick)
    else $error("feedback tick longer than one cycle");
  a_sdo_in_frame: assert property ($rose(port_sdo_oe) |-> !port_cs_n)
    else $error("read data driven outside a frame");
endmodule // clock_pll_config_regs_sva

bind clock_pll_config_regs clock_pll_config_regs_sva #(.LANES(LANES)) i_clock_pll_config_regs_sva (
  .clock(clock), .nrst(nrst), .port_cs_n(port_cs_n), .pll_enable_pin(pll_enable_pin),
  .clock_pll_reset(clock_pll_reset), .oscillator_tick(oscillator_tick), .port_sdo_oe(port_sdo_oe),
  .ref_clock_output_pins(ref_clock_output_pins), .ref_clock_output_oe(ref_clock_output_oe),
  .sampling_clock_tick(sampling_clock_tick), .feedback_clock_tick(feedback_clock_tick),
  .oscillator_bias_level(oscillator_bias_level), .lane_preemphasis(lane_preemphasis));

// >>> tb/host_port_model.sv
// Host model: serial control port master that sequences the divider reset
`timescale 1ns/1ns
module host_port_model (
  input wire clock,
  input wire port_sdo,
  output reg port_sclk,
  output reg port_cs_n,
  output reg port_sdi,
  output reg clock_pll_reset
);
  // Six clocks per phase leaves margin over the five-clock minimum
  localparam HALF = 6;
  initial begin
    port_sclk = 1'b0;
    port_cs_n = 1'b1;
    port_sdi = 1'b0;
    clock_pll_reset = 1'b0;
  end
  // One 24-bit frame, MSB first; read bits taken at the end of each low phase
  task frame(input logic rd, input logic [14:0] addr, input logic [7:0] wd, output logic [7:0] rdata);
    logic [23:0] sh;
    integer i;
    sh = {rd, addr, wd};
    rdata = 8'h00;
    if (!rd && (addr == 15'h003D || addr == 15'h003E))
      clock_pll_reset <= 1'b1;
    port_cs_n <= 1'b0;
    for (i = 0; i < 24; i = i + 1) begin
      port_sdi <= sh[23-i];
      repeat (HALF) @(posedge clock);
      if (i >= 16)
        rdata = {rdata[6:0], port_sdo};
      port_sclk <= 1'b1;
      repeat (HALF) @(posedge clock);
      port_sclk <= 1'b0;
    end
    repeat (HALF) @(posedge clock);
    port_cs_n <= 1'b1;
    port_sdi <= ~sh[0]; // Released line shows no stale bit
    repeat (HALF) @(posedge clock);
    clock_pll_reset <= 1'b0;
    // One more edge so a following frame never re-drives the reset in this time step
    @(posedge clock);
  endtask
endmodule // host_port_model

// >>> tb/test_clock_pll_config_regs.sv
// Self-checking bench for the clock synthesizer register group
`timescale 1ns/1ns
module test_clock_pll_config_regs;
  reg clock, nrst, pll_enable_pin, oscillator_tick, counting;
  wire port_sclk, port_cs_n, port_sdi, clock_pll_reset, port_sdo, port_sdo_oe;
  wire ref_clock_output_pins, ref_clock_output_oe, sampling_clock_tick, feedback_clock_tick;
  wire [6:0] oscillator_bias_level;
  wire [31:0] lane_preemphasis;
  integer err_count, n_tests, s_cnt, f_cnt, r_cnt, f, s;
  logic [7:0] rd;
  clock_pll_config_regs i_clock_pll_config_regs (.clock(clock), .nrst(nrst), .port_sclk(port_sclk),
    .port_cs_n(port_cs_n), .port_sdi(port_sdi), .pll_enable_pin(pll_enable_pin),
    .clock_pll_reset(clock_pll_reset), .oscillator_tick(oscillator_tick), .port_sdo(port_sdo),
    .port_sdo_oe(port_sdo_oe), .ref_clock_output_pins(ref_clock_output_pins),
    .ref_clock_output_oe(ref_clock_output_oe), .sampling_clock_tick(sampling_clock_tick),
    .feedback_clock_tick(feedback_clock_tick), .oscillator_bias_level(oscillator_bias_level),
    .lane_preemphasis(lane_preemphasis));
  host_port_model i_host_port_model (.clock(clock), .port_sdo(port_sdo), .port_sclk(port_sclk),
    .port_cs_n(port_cs_n), .port_sdi(port_sdi), .clock_pll_reset(clock_pll_reset));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Tick counters for the divider runs; cleared here only, so each has one driver
  always @(posedge clock) begin
    if (!counting) begin
      s_cnt <= 0;
      f_cnt <= 0;
      r_cnt <= 0;
    end else begin
      s_cnt <= s_cnt + sampling_clock_tick;
      f_cnt <= f_cnt + feedback_clock_tick;
      r_cnt <= r_cnt + ref_clock_output_pins;
    end
  end
  task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    i_host_port_model.frame(1'b0, a, d, dummy);
  endtask
  task rdc(input logic [14:0] a, input logic [7:0] e);
    i_host_port_model.frame(1'b1, a, 8'h00, rd);
    chk("readback", {24'h0, rd}, {24'h0, e});
  endtask
  // Reserved code 3 decodes like code 0
  function integer r1(input integer c);
    r1 = (c == 1) ? 4 : (c == 2) ? 3 : 5;
  endfunction
  function integer r2(input integer c);
    r2 = (c == 1) ? 2 : (c == 2) ? 4 : 1;
  endfunction
  // Exactly two feedback periods of oscillator ticks, then a quiet flush
  task run_div(input integer fc, input integer sc, input integer t);
    integer k, i;
    k = r1(fc) * r2(sc) * t * 2;
    wr(15'h003D, {4'h0, sc[1:0], fc[1:0]});
    wr(15'h003E, {2'h0, t[5:0]});
    counting = 1'b1;
    for (i = 0; i < k; i = i + 1) begin
      @(posedge clock) oscillator_tick <= 1'b1;
      @(posedge clock) oscillator_tick <= 1'b0;
    end
    repeat (8) @(posedge clock);
    counting = 1'b0;
    chk("sampling ticks", s_cnt, k / (r1(fc) * r2(sc)));
    chk("feedback ticks", f_cnt, 2);
    chk("ref pin ticks", r_cnt, k);
  endtask
  task end_sim;
    if (err_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Run needs about 20k cycles; a hang stops well past that
  initial begin
    #(50 * 60000);
    err_count = err_count + 1;
    end_sim;
  end
  initial begin
    err_count = 0;
    n_tests = 0;
    nrst = 1'b0;
    pll_enable_pin = 1'b1;
    oscillator_tick = 1'b0;
    counting = 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    repeat (6) @(posedge clock);
    #1;
    chk("bias out", oscillator_bias_level, 7'h4F);
    chk("ref oe", ref_clock_output_oe, 1'b1);
    rdc(15'h003C, 8'h01);
    rdc(15'h003D, 8'h00);
    rdc(15'h003E, 8'h20);
    rdc(15'h003F, 8'h4F);
    rdc(15'h0048, 8'h00);
    rdc(15'h0040, 8'h00); // Unmapped place reads zero
    wr(15'h003C, 8'h00);
    @(posedge clock);
    #1;
    chk("ref oe off", ref_clock_output_oe, 1'b0);
    wr(15'h003C, 8'h01);
    pll_enable_pin <= 1'b0;
    repeat (5) @(posedge clock);
    #1;
    chk("ref oe pll low", ref_clock_output_oe, 1'b0);
    pll_enable_pin <= 1'b1;
    repeat (5) @(posedge clock);
    #1;
    chk("ref oe back", ref_clock_output_oe, 1'b1);
    for (f = 0; f < 4; f = f + 1)
      for (s = 0; s < 4; s = s + 1)
        run_div(f, s, 3);
    run_div(2, 0, 63);
    wr(15'h0048, 8'h0B);
    wr(15'h003F, 8'h4A);
    @(posedge clock);
    #1;
    chk("lanes", lane_preemphasis, {8{4'hB}});
    chk("bias out", oscillator_bias_level, 7'h4A);
    rdc(15'h003D, 8'h02);
    rdc(15'h003E, 8'h3F);
    // Reset in mid-run must bring the emphasis, bias and third divider registers back to their defaults
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    repeat (6) @(posedge clock);
    rdc(15'h0048, 8'h00);
    rdc(15'h003F, 8'h4F);
    rdc(15'h003E, 8'h20);
    end_sim;
  end
endmodule // test_clock_pll_config_regs
